// ---- rtl/aem_pkg.sv ----
// Constants, types and helper functions for the add-only EPROM front end
package aem_pkg;
	// Memory-function command bytes
	localparam logic [7:0] CMD_RD_MEM = 8'hF0;
	localparam logic [7:0] CMD_RD_STAT = 8'hAA;
	localparam logic [7:0] CMD_WR_MEM = 8'h0F;
	localparam logic [7:0] CMD_WR_STAT = 8'h55;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_TX = 8'h08;
	localparam logic [7:0] REG_RX = 8'h0C;
	localparam logic [7:0] REG_ID_LO = 8'h10;
	localparam logic [7:0] REG_ID_HI = 8'h14;
	localparam logic [7:0] REG_CRC = 8'h18;
	localparam logic [7:0] REG_ADDR = 8'h1C;
	// Control bits
	localparam int CTRL_BUS_RST = 0;
	localparam int CTRL_ROM_SEL = 1;
	localparam int CTRL_PROG = 2;
	// Status bits
	localparam int ST_SEL = 0;
	localparam int ST_VPP = 1;
	localparam int ST_REFUSED = 2;
	localparam int ST_BLOCKED = 3;
	localparam int ST_FIELD_END = 4;
	localparam int ST_WAIT_PROG = 5;
	localparam int ST_ID_DONE = 6;
	// Memory geometry
	localparam int PAGES = 64;
	localparam int PAGE_BYTES = 32;
	localparam int DATA_BYTES = PAGES * PAGE_BYTES;
	localparam int STAT_BYTES = 88;
	localparam logic [7:0] ERASED = 8'hFF;
	// Status field blocks (address bits 10:3; redirection block on bits 10:6) and their array bases
	localparam logic [7:0] SB_WP_PAGE = 8'h00;
	localparam logic [7:0] SB_WP_REDIR = 8'h04;
	localparam logic [7:0] SB_BITMAP = 8'h08;
	localparam logic [4:0] SB_REDIR = 5'h04;
	localparam logic [6:0] IX_WP_PAGE = 7'h00;
	localparam logic [6:0] IX_WP_REDIR = 7'h08;
	localparam logic [6:0] IX_BITMAP = 7'h10;
	localparam logic [6:0] IX_REDIR = 7'h18;
	// CRC generators, bit-reversed for LSB-first shifting
	localparam logic [7:0] CRC8_POLY = 8'h8C;
	localparam logic [15:0] CRC16_POLY = 16'hA001;
	localparam logic [2:0] ID_LAST_BYTE = 3'h6;

	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} aem_ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} aem_ahb_rsp_t;

	typedef enum logic [6:0] {
		S_CMD = 7'b0000001,
		S_AL = 7'b0000010,
		S_AH = 7'b0000100,
		S_RD = 7'b0001000,
		S_WD = 7'b0010000,
		S_WP = 7'b0100000,
		S_WV = 7'b1000000
	} aem_state_t;

	// Bit-serial identity check over a whole 64-bit word, LSB first
	function automatic logic [7:0] aem_crc8_bits(input logic [63:0] v);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 64; i++) begin
			c = (c >> 1) ^ ((c[0] ^ v[i]) ? CRC8_POLY : 8'h00);
		end
		return c;
	endfunction
endpackage

// ---- rtl/aem_crc_unit.sv ----
// Byte-wide CRC accumulator that shifts each byte in LSB first
`timescale 1ns/1ps
module aem_crc_unit #(
	parameter int W = 8,
	parameter logic [W-1:0] POLY = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic en,
	input wire logic [7:0] din,
	output logic [W-1:0] crc
);
	logic [W-1:0] chain [9];

	assign chain[0] = clr ? '0 : crc;
	generate
		for (genvar i = 0; i < 8; i++) begin : g_bit
			assign chain[i+1] = (chain[i] >> 1) ^ ((chain[i][0] ^ din[i]) ? POLY : '0);
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			crc <= '0;
		end else if (en) begin
			crc <= chain[8];
		end else if (clr) begin
			crc <= '0;
		end
	end
endmodule

// ---- rtl/aem_frontend.sv ----
// Add-only EPROM front end: identity, command framing, data and status memory
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - Fixed 64-bit identity: family byte, 48-bit serial, 8-bit check value.
// - Memory commands are refused until ROM-level selection completes after reset.
// - Identity check uses polynomial x^8 + x^5 + x^4 + 1.
// - Check accumulator starts at zero; family then serial shifted in LSB first.
// - Data EPROM is sixty-four pages of 32 bytes, byte addressed.
// - Byte buffered in scratchpad, 16-bit check returned, committed on programming voltage.
// - Separate 704-bit status memory spanning 000 to 13FH.
// - Status 000-007H hold page write-protect bits; protected pages refuse programming.
// - Status 020-027H protect bits freeze each page's redirection byte.
// - Status 040-047H in-use bitmap has no effect on device logic.
// - Redirection bytes 100H-13FH are stored and returned, never used for decisions.
// - Programming only moves bits from 1 to 0.
// - Unimplemented status addresses read FFH; writes to them are ignored.
// - Status start address above 7FFH has its five top bits forced to zero.
// - One byte per programming sequence: load scratchpad, then pulse.
// - Reads run from start address to end of the selected field; redirection reads stop at each 8-byte boundary.
// - All bits travel least significant bit first.
// - Programming voltage on the line raises an internal qualify signal.
module aem_frontend
	import aem_pkg::*;
#(
	parameter logic [7:0] FAMILY_CODE = 8'h5A,
	parameter logic [47:0] SERIAL_NUM = 48'h0123_4567_89AB
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire aem_pkg::aem_ahb_req_t ahb_req,
	output aem_pkg::aem_ahb_rsp_t ahb_rsp,
	input wire logic vpp_hv
);
	// FAMILY_CODE and SERIAL_NUM defaults are arbitrary values
	aem_state_t state_r;
	aem_ahb_rsp_t rsp_r;
	logic sel_r, refused_r, blocked_r, vpp_r, id_done_r, dph_wr_r;
	logic [7:0] dph_off_r, cmd_r, scratch_r, id_crc;
	logic [15:0] addr_r, crc16;
	logic [2:0] id_cnt_r;
	logic [7:0] mem_data [DATA_BYTES];
	logic [7:0] mem_stat [STAT_BYTES];
	logic [DATA_BYTES-1:0] data_wr_r;
	logic [STAT_BYTES-1:0] stat_wr_r;

	assign ahb_rsp = rsp_r;

	// Bus events
	logic addr_take, tx_ev, ctrl_ev, stat_ev, rx_ev;
	logic [31:0] wdat;
	assign addr_take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
	assign wdat = ahb_req.hwdata;
	assign tx_ev = dph_wr_r && (dph_off_r == REG_TX);
	assign ctrl_ev = dph_wr_r && (dph_off_r == REG_CTRL);
	assign stat_ev = dph_wr_r && (dph_off_r == REG_STATUS);
	assign rx_ev = addr_take && !ahb_req.hwrite && (ahb_req.haddr[7:0] == REG_RX);

	logic bus_rst, prog_ev, is_stat, is_read, cmd_ok;
	assign bus_rst = ctrl_ev && wdat[CTRL_BUS_RST];
	assign prog_ev = ctrl_ev && wdat[CTRL_PROG] && (state_r == S_WP) && vpp_r;
	assign is_stat = (cmd_r == CMD_RD_STAT) || (cmd_r == CMD_WR_STAT);
	assign is_read = (cmd_r == CMD_RD_MEM) || (cmd_r == CMD_RD_STAT);
	assign cmd_ok = (wdat[7:0] == CMD_RD_MEM) || (wdat[7:0] == CMD_RD_STAT)
		|| (wdat[7:0] == CMD_WR_MEM) || (wdat[7:0] == CMD_WR_STAT);

	// Status address decode into the packed status array
	logic stat_hit, is_redir;
	logic [6:0] stat_idx;
	always_comb begin
		stat_hit = 1'b1;
		is_redir = 1'b0;
		stat_idx = IX_WP_PAGE;
		if (addr_r[10:3] == SB_WP_PAGE) begin
			stat_idx = IX_WP_PAGE + {4'h0, addr_r[2:0]};
		end else if (addr_r[10:3] == SB_WP_REDIR) begin
			stat_idx = IX_WP_REDIR + {4'h0, addr_r[2:0]};
		end else if (addr_r[10:3] == SB_BITMAP) begin
			stat_idx = IX_BITMAP + {4'h0, addr_r[2:0]};
		end else if (addr_r[10:6] == SB_REDIR) begin
			is_redir = 1'b1;
			stat_idx = IX_REDIR + {1'b0, addr_r[5:0]};
		end else begin
			stat_hit = 1'b0;
		end
	end

	function automatic logic [7:0] stat_val(input logic [6:0] i);
		return stat_wr_r[i] ? mem_stat[i] : ERASED;
	endfunction

	// Current byte under the address counter; erased cells read FFH
	logic [10:0] data_ix;
	logic [7:0] cur_byte;
	logic [5:0] page, rpage;
	logic [7:0] wp_page_byte, wp_redir_byte;
	logic prot, field_last, commit_mem, commit_stat;
	assign data_ix = addr_r[10:0];
	assign page = addr_r[10:5];
	assign rpage = addr_r[5:0];
	always_comb begin
		if (is_stat) begin
			cur_byte = stat_hit ? stat_val(stat_idx) : ERASED;
		end else begin
			cur_byte = data_wr_r[data_ix] ? mem_data[data_ix] : ERASED;
		end
	end
	always_comb begin
		wp_page_byte = stat_val(IX_WP_PAGE + {4'h0, page[5:3]});
		wp_redir_byte = stat_val(IX_WP_REDIR + {4'h0, rpage[5:3]});
	end
	// Only the two protect fields gate programming; bitmap and redirection never do
	assign prot = is_stat ? (is_redir && !wp_redir_byte[rpage[2:0]])
		: !wp_page_byte[page[2:0]];
	assign field_last = is_stat ? (addr_r[2:0] == 3'h7) : (data_ix == 11'h7FF);
	assign commit_mem = prog_ev && !is_stat && !prot;
	assign commit_stat = prog_ev && is_stat && stat_hit && !prot;

	// Arrays carry no reset; written flags make untouched cells read erased
	always_ff @(posedge hclk) begin
		if (commit_mem) begin
			mem_data[data_ix] <= cur_byte & scratch_r;
		end
		if (commit_stat) begin
			mem_stat[stat_idx] <= cur_byte & scratch_r;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_wr_r <= '0;
			stat_wr_r <= '0;
		end else begin
			if (commit_mem) begin
				data_wr_r[data_ix] <= 1'b1;
			end
			if (commit_stat) begin
				stat_wr_r[stat_idx] <= 1'b1;
			end
		end
	end

	// Identity check computed once after reset
	logic [55:0] id_body;
	assign id_body = {SERIAL_NUM, FAMILY_CODE};
	aem_crc_unit #(.W(8), .POLY(CRC8_POLY)) u_id_crc (
		.clk(hclk),
		.rst_n(hresetn),
		.clr(1'b0),
		.en(!id_done_r),
		.din(id_body[{id_cnt_r, 3'b000} +: 8]),
		.crc(id_crc)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			id_cnt_r <= 3'h0;
			id_done_r <= 1'b0;
		end else if (!id_done_r) begin
			id_cnt_r <= id_cnt_r + 3'h1;
			id_done_r <= (id_cnt_r == ID_LAST_BYTE);
		end
	end

	// Running 16-bit check over command, address and data
	logic crc_clr, crc_en;
	logic [7:0] crc_din, addr_hi_m;
	assign addr_hi_m = is_stat ? {5'h00, wdat[2:0]} : wdat[7:0];
	always_comb begin
		crc_clr = 1'b0;
		crc_en = 1'b0;
		crc_din = wdat[7:0];
		case (state_r)
			S_CMD: begin
				crc_clr = tx_ev;
				crc_en = tx_ev && sel_r && cmd_ok;
			end
			S_AL, S_WD: crc_en = tx_ev;
			S_AH: begin
				crc_en = tx_ev;
				crc_din = addr_hi_m;
			end
			S_RD: begin
				crc_en = rx_ev;
				crc_din = cur_byte;
			end
			S_WV: crc_clr = rx_ev;
			default: crc_clr = 1'b0;
		endcase
	end

	aem_crc_unit #(.W(16), .POLY(CRC16_POLY)) u_crc16 (
		.clk(hclk),
		.rst_n(hresetn),
		.clr(crc_clr),
		.en(crc_en),
		.din(crc_din),
		.crc(crc16)
	);

	// Selection, voltage detect and sticky flags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_r <= 1'b0;
		end else if (bus_rst) begin
			sel_r <= 1'b0;
		end else if (ctrl_ev && wdat[CTRL_ROM_SEL]) begin
			sel_r <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vpp_r <= 1'b0;
		end else begin
			vpp_r <= vpp_hv;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			refused_r <= 1'b0;
			blocked_r <= 1'b0;
		end else begin
			if (state_r == S_CMD && tx_ev && !(sel_r && cmd_ok)) begin
				refused_r <= 1'b1;
			end else if (stat_ev && wdat[ST_REFUSED]) begin
				refused_r <= 1'b0;
			end
			if (prog_ev && prot) begin
				blocked_r <= 1'b1;
			end else if (stat_ev && wdat[ST_BLOCKED]) begin
				blocked_r <= 1'b0;
			end
		end
	end

	// Command framing and address counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= S_CMD;
			cmd_r <= 8'h00;
			addr_r <= 16'h0000;
			scratch_r <= ERASED;
		end else if (bus_rst) begin
			state_r <= S_CMD;
		end else begin
			case (state_r)
				S_CMD: if (tx_ev && sel_r && cmd_ok) begin
					cmd_r <= wdat[7:0];
					state_r <= S_AL;
				end
				S_AL: if (tx_ev) begin
					addr_r[7:0] <= wdat[7:0];
					state_r <= S_AH;
				end
				S_AH: if (tx_ev) begin
					addr_r[15:8] <= addr_hi_m;
					state_r <= is_read ? S_RD : S_WD;
				end
				S_WD: if (tx_ev) begin
					scratch_r <= wdat[7:0];
					state_r <= S_WP;
				end
				S_WP: if (prog_ev) begin
					state_r <= S_WV;
				end
				S_WV: if (rx_ev) begin
					addr_r <= addr_r + 16'h0001;
					state_r <= S_WD;
				end
				S_RD: if (rx_ev && !field_last) begin
					addr_r <= addr_r + 16'h0001;
				end else if (rx_ev) begin
					state_r <= S_CMD;
					cmd_r <= 8'h00;
				end
				default: state_r <= S_CMD;
			endcase
		end
	end

	// AHB-Lite slave: zero wait states, read data registered at the address phase
	logic [31:0] rd_mux;
	logic [31:0] status_word;
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[ST_SEL] = sel_r;
		status_word[ST_VPP] = vpp_r;
		status_word[ST_REFUSED] = refused_r;
		status_word[ST_BLOCKED] = blocked_r;
		status_word[ST_FIELD_END] = (state_r == S_CMD) && (cmd_r == 8'h00);
		status_word[ST_WAIT_PROG] = (state_r == S_WP);
		status_word[ST_ID_DONE] = id_done_r;
		case (ahb_req.haddr[7:0])
			REG_CTRL: rd_mux = {29'h0, 1'b0, sel_r, 1'b0};
			REG_STATUS: rd_mux = status_word;
			REG_RX: rd_mux = {24'h0, ((state_r == S_RD) || (state_r == S_WV)) ? cur_byte : ERASED};
			REG_ID_LO: rd_mux = {SERIAL_NUM[23:0], FAMILY_CODE};
			REG_ID_HI: rd_mux = {id_crc, SERIAL_NUM[47:24]};
			REG_CRC: rd_mux = {16'h0000, crc16};
			REG_ADDR: rd_mux = {16'h0000, addr_r};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_wr_r <= 1'b0;
			dph_off_r <= 8'h00;
		end else begin
			dph_wr_r <= addr_take && ahb_req.hwrite;
			dph_off_r <= ahb_req.haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rsp_r <= '{hrdata: 32'h0000_0000, hreadyout: 1'b1, hresp: 1'b0};
		end else begin
			rsp_r.hreadyout <= 1'b1;
			rsp_r.hresp <= 1'b0;
			if (addr_take && !ahb_req.hwrite) begin
				rsp_r.hrdata <= rd_mux;
			end
		end
	end

	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_cmd_unsel;
		(state_r == S_CMD) && tx_ev && !sel_r;
	endsequence
	sequence s_prog_prot;
		prog_ev && prot;
	endsequence
	sequence s_last_read;
		(state_r == S_RD) && rx_ev && field_last && !bus_rst;
	endsequence

	a_refuse_unselected: assert property (s_cmd_unsel |=> (state_r == S_CMD) && refused_r)
		else $error("memory command accepted without selection");
	a_id_check_zero: assert property (id_done_r |-> aem_crc8_bits({id_crc, id_body}) == 8'h00)
		else $error("identity check value does not close to zero");
	a_id_done_time: assert property ($rose(id_cnt_r == 3'h1) |-> ##6 $rose(id_done_r))
		else $error("identity check not ready after seven bytes");
	a_protect_block: assert property (s_prog_prot |=> $stable(cur_byte) && blocked_r)
		else $error("protected byte was altered");
	a_one_to_zero: assert property (prog_ev |=> (cur_byte & ~$past(cur_byte)) == 8'h00)
		else $error("programming raised a bit");
	a_vpp_gate: assert property ((state_r == S_WP) && !vpp_r |=> (state_r == S_WP) || $past(bus_rst))
		else $error("programming left wait without voltage");
	a_addr_step: assert property ((state_r == S_RD) && rx_ev && !field_last && !bus_rst
		|=> addr_r == $past(addr_r) + 16'h0001)
		else $error("address counter did not step");
	a_read_end: assert property (s_last_read |=> (state_r == S_CMD) ##1 status_word[ST_FIELD_END])
		else $error("read did not stop at field end");
	a_stat_mask: assert property ((state_r == S_AH) && tx_ev && is_stat && !bus_rst
		|=> addr_r[15:11] == 5'h00)
		else $error("status address top bits not cleared");
	a_unimpl_erased: assert property (is_stat && !stat_hit |-> cur_byte == ERASED)
		else $error("unimplemented status byte not FFH");
endmodule

// ---- testbench/aem_host_model.sv ----
// Bus master model: AHB-Lite single word transfers and the programming-voltage line
`timescale 1ns/1ps
module aem_host_model
	import aem_pkg::*;
(
	input wire logic hclk,
	output aem_pkg::aem_ahb_req_t ahb_req,
	input wire aem_pkg::aem_ahb_rsp_t ahb_rsp,
	output logic vpp_hv
);
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic vpp = 1'b0;

	always_comb begin
		ahb_req.hsel = hsel;
		ahb_req.haddr = haddr;
		ahb_req.htrans = htrans;
		ahb_req.hwrite = hwrite;
		ahb_req.hsize = 3'h2;
		ahb_req.hwdata = hwdata;
		ahb_req.hready = ahb_rsp.hreadyout;
	end
	assign vpp_hv = vpp;

	// One single transfer; each phase is held until hready is seen high
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output bit to);
		int n;
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (ahb_rsp.hreadyout !== 1'b1 && n < 50);
		to = (n >= 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		haddr <= ~haddr;
		hwdata <= wd;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (ahb_rsp.hreadyout !== 1'b1 && n < 50);
		to = to || (n >= 50);
		rd = ahb_rsp.hrdata;
		// Released data lines must not keep the last value
		hwdata <= ~wd;
	endtask

	task automatic set_vpp(input logic v);
		@(posedge hclk);
		vpp <= v;
	endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the add-only EPROM front end
`timescale 1ns/1ps
module testbench;
	import aem_pkg::*;
	localparam logic [7:0] FAM = 8'h5A; // Arbitrary family value
	localparam logic [47:0] SER = 48'h0123_4567_89AB; // Arbitrary serial value
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	aem_ahb_req_t ahb_req;
	aem_ahb_rsp_t ahb_rsp;
	logic vpp_hv;
	int bad_count = 0;
	int tests_run = 0;

	aem_frontend #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER)) uut (.hclk(hclk),
		.hresetn(hresetn), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .vpp_hv(vpp_hv));
	aem_host_model host (.hclk(hclk), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
		.vpp_hv(vpp_hv));

	initial begin
		forever #2.5 hclk = ~hclk;
	end

	task automatic print_verdict();
		if (bad_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic flag(input string nm, input logic [31:0] v, input int i, input logic e);
		check(nm, {31'h0, v[i]}, {31'h0, e});
	endtask

	// Reflected x^8 + x^5 + x^4 + 1, zero start, LSB first
	function automatic logic [7:0] crc8(input logic [63:0] v, input int nb);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < nb; i++) begin
			c = {1'b0, c[7:1]} ^ ((c[0] ^ v[i]) ? 8'h8C : 8'h00);
		end
		return c;
	endfunction

	function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			c = {1'b0, c[15:1]} ^ ((c[0] ^ b[i]) ? 16'hA001 : 16'h0000);
		end
		return c;
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		bit to;
		host.xfer(1'b1, a, d, v, to);
		if (to) begin
			bad_count++;
			print_verdict();
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		bit to;
		host.xfer(1'b0, a, 32'h0, v, to);
		if (to) begin
			bad_count++;
			print_verdict();
		end
	endtask

	// Bus reset and selection first, then command and two address bytes, low byte first
	task automatic start(input logic [7:0] cmd, input logic [15:0] a);
		wr(REG_CTRL, 32'h1);
		wr(REG_CTRL, 32'h2);
		wr(REG_TX, {24'h0, cmd});
		wr(REG_TX, {24'h0, a[7:0]});
		wr(REG_TX, {24'h0, a[15:8]});
	endtask

	task automatic rx(input string nm, input logic [31:0] e);
		logic [31:0] v;
		rd(REG_RX, v);
		check(nm, v, e);
	endtask

	task automatic prog(input logic [7:0] cmd, input logic [15:0] a, input logic [7:0] d,
		input logic [7:0] e);
		logic [31:0] v;
		logic [15:0] c;
		c = crc16(crc16(crc16(crc16(16'h0000, cmd), a[7:0]), a[15:8]), d);
		start(cmd, a);
		wr(REG_TX, {24'h0, d});
		rd(REG_CRC, v);
		check("prog_crc", v, {16'h0, c});
		host.set_vpp(1'b1);
		rd(REG_STATUS, v);
		flag("vpp_seen", v, ST_VPP, 1'b1);
		flag("wait_pulse", v, ST_WAIT_PROG, 1'b1);
		wr(REG_CTRL, 32'h4);
		host.set_vpp(1'b0);
		rx("verify_byte", {24'h0, e});
	endtask

	task automatic t_identity();
		logic [31:0] v;
		int n;
		n = 0;
		do begin
			rd(REG_STATUS, v);
			n++;
		end while (v[ST_ID_DONE] !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			print_verdict();
		end
		rd(REG_ID_LO, v);
		check("id_lo", v, {SER[23:0], FAM});
		rd(REG_ID_HI, v);
		check("id_hi", v, {crc8({8'h00, SER, FAM}, 56), SER[47:24]});
		check("id_residue", {24'h0, crc8({v[31:24], SER, FAM}, 64)}, 32'h0);
	endtask

	task automatic t_refuse();
		logic [31:0] v;
		wr(REG_TX, {24'h0, CMD_RD_MEM});
		rd(REG_STATUS, v);
		flag("refused", v, ST_REFUSED, 1'b1);
		flag("not_selected", v, ST_SEL, 1'b0);
		wr(REG_STATUS, 32'h4);
		rd(REG_STATUS, v);
		flag("refused_clear", v, ST_REFUSED, 1'b0);
		rd(8'h20, v);
		check("unmapped", v, 32'h0);
	endtask

	task automatic t_read_data();
		logic [31:0] v;
		start(CMD_RD_MEM, 16'h07FE);
		rd(REG_ADDR, v);
		check("addr_load", v, 32'h7FE);
		rx("erased", 32'hFF);
		rd(REG_ADDR, v);
		check("addr_step", v, 32'h7FF);
		rd(REG_STATUS, v);
		flag("mid_field", v, ST_FIELD_END, 1'b0);
		rx("last_byte", 32'hFF);
		rd(REG_STATUS, v);
		flag("field_end", v, ST_FIELD_END, 1'b1);
	endtask

	task automatic t_program();
		logic [31:0] v;
		start(CMD_WR_MEM, 16'h0040);
		wr(REG_TX, 32'hA5);
		wr(REG_CTRL, 32'h4);
		rd(REG_STATUS, v);
		flag("no_vpp_no_prog", v, ST_WAIT_PROG, 1'b1);
		prog(CMD_WR_MEM, 16'h0040, 8'hA5, 8'hA5);
		wr(REG_TX, 32'h3C);
		host.set_vpp(1'b1);
		wr(REG_CTRL, 32'h4);
		host.set_vpp(1'b0);
		rx("next_byte", 32'h3C);
		start(CMD_RD_MEM, 16'h0040);
		rx("read_a", 32'hA5);
		rx("read_b", 32'h3C);
		prog(CMD_WR_MEM, 16'h0040, 8'hF0, 8'hA0);
	endtask

	task automatic t_protect();
		logic [31:0] v;
		prog(CMD_WR_STAT, 16'h0000, 8'hFE, 8'hFE);
		prog(CMD_WR_MEM, 16'h0005, 8'h00, 8'hFF);
		rd(REG_STATUS, v);
		flag("blocked", v, ST_BLOCKED, 1'b1);
		wr(REG_STATUS, 32'h8);
		start(CMD_RD_MEM, 16'h0005);
		rx("protected_read", 32'hFF);
		prog(CMD_WR_STAT, 16'h0040, 8'h00, 8'h00);
		prog(CMD_WR_MEM, 16'h0060, 8'h11, 8'h11);
		prog(CMD_WR_STAT, 16'h0101, 8'hFD, 8'hFD);
		prog(CMD_WR_STAT, 16'h0020, 8'hFC, 8'hFC);
		prog(CMD_WR_MEM, 16'h0020, 8'h22, 8'h22);
		prog(CMD_WR_STAT, 16'h0101, 8'h00, 8'hFD);
		prog(CMD_WR_STAT, 16'h0100, 8'h00, 8'hFF);
		start(CMD_RD_STAT, 16'h0100);
		rx("redir_p0", 32'hFF);
		rd(REG_RX, v);
		check("redir_p1", v, 32'hFD);
		// Follow the redirection: the complement is the replacement page
		start(CMD_RD_MEM, {3'h0, ~v[7:0], 5'h00});
		rx("redir_target", 32'hA0);
	endtask

	task automatic t_reset();
		logic [31:0] v;
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		wr(REG_TX, {24'h0, CMD_RD_MEM});
		rd(REG_STATUS, v);
		flag("reset_unselected", v, ST_SEL, 1'b0);
		flag("reset_refused", v, ST_REFUSED, 1'b1);
	endtask

	task automatic t_unimpl();
		logic [31:0] v;
		prog(CMD_WR_STAT, 16'h0010, 8'h00, 8'hFF);
		prog(CMD_WR_STAT, 16'h0140, 8'h00, 8'hFF);
		start(CMD_RD_STAT, 16'h0010);
		rx("unimpl_read", 32'hFF);
		start(CMD_RD_STAT, 16'h0800);
		rd(REG_ADDR, v);
		check("addr_masked", v, 32'h0);
		rd(REG_CRC, v);
		check("crc_masked", v, {16'h0, crc16(crc16(crc16(16'h0, 8'hAA), 8'h00), 8'h00)});
		rx("masked_byte", 32'hFE);
	endtask

	initial begin
		repeat (4) @(posedge hclk);
		check("rst_ready", {31'h0, ahb_rsp.hreadyout}, 32'h1);
		check("rst_resp", {31'h0, ahb_rsp.hresp}, 32'h0);
		check("rst_rdata", ahb_rsp.hrdata, 32'h0);
		hresetn <= 1'b1;
		t_identity();
		t_refuse();
		t_read_data();
		t_program();
		t_protect();
		t_unimpl();
		t_reset();
		print_verdict();
	end
endmodule
